//--- hdl/gdfm_pkg.sv
package gdfm_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DISABLE_OFS = 8'h04;
    localparam logic [7:0] MODE_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] LIVE_OFS = 8'h10;
    // Control register fields
    localparam int CLR_BIT = 0;
    // Disable register fields
    localparam int DIS_SUP_UV = 0;
    localparam int DIS_SUP_OV = 1;
    localparam int DIS_PUMP_UV = 2;
    localparam int DIS_GATE = 3;
    localparam int DIS_TSD = 4;
    localparam int DIS_BUCK_OC = 5;
    localparam int DIS_DRV_UV = 6;
    localparam int DIS_DRV_OV = 7;
    localparam int DIS_W = 8;
    localparam logic [7:0] DIS_RST = 8'h00;
    // Mode register fields
    localparam int MODE_DRAIN_LSB = 0;
    localparam int MODE_SENSE_LSB = 2;
    localparam int MODE_PD_BIT = 4;
    localparam int MODE_TWREP_BIT = 5;
    localparam int MODE_W = 6;
    localparam logic [5:0] MODE_RST = 6'h00;
    // Overcurrent modes
    localparam logic [1:0] OC_LATCH_BLOCK = 2'h0;
    localparam logic [1:0] OC_RETRY = 2'h1;
    localparam logic [1:0] OC_REPORT = 2'h2;
    localparam logic [1:0] OC_OFF = 2'h3;
    // Status register fields
    localparam int ST_ANY = 0;
    localparam int ST_SUP_UV = 1;
    localparam int ST_SUP_OV = 2;
    localparam int ST_PUMP_UV = 3;
    localparam int ST_DRAIN = 4;
    localparam int ST_SENSE = 5;
    localparam int ST_GATE = 6;
    localparam int ST_TWARN = 7;
    localparam int ST_TSD = 8;
    localparam int ST_BUCK_OC = 9;
    localparam int ST_DRV_UV = 10;
    localparam int ST_DRV_OV = 11;
    localparam int ST_W = 12;
    // Live register fields
    localparam int LV_MODE_LSB = 0;
    localparam int LV_BLOCK = 2;
    localparam int LV_FAULT = 3;
    localparam int LV_STBY = 4;
    localparam int LV_DRV_LDO = 5;
    localparam int LV_BUCK = 6;
    localparam int LV_HICCUP = 7;
    localparam int LV_HIZ = 8;
    localparam int LV_W = 9;
    // Synchronised input vector layout
    localparam int IN_W = 19;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int OC_RETRY_TIME_NS = 100000;
    localparam int OC_RETRY_CYCLES = OC_RETRY_TIME_NS / CLK_PERIOD_NS;
    localparam int RETRY_CNT_W = 24;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Operating modes
    typedef enum logic [1:0] {
        GDFM_SHUTDOWN,
        GDFM_SLEEP,
        GDFM_OPERATING
    } gdfm_mode_t;
endpackage : gdfm_pkg

//--- hdl/gdfm_fault_manager.sv
`timescale 1ns/1ps
// What this block does
// - Core undervoltage: no report, gates blocked, standby+logic regulators only, sleep afterwards.
// - Disabled detection other than gate check: only status bit set, drivers active, regulators unchanged.
// - Pump rail undervoltage: pin low, status, gates blocked, all but standby on.
// - Drain overcurrent mode 00 latches and blocks; mode 10 latches, drivers active.
// - Sense overcurrent on any amplifier: same latched scheme as drain overcurrent.
// - Overcurrent mode 11 or gate check disabled: no report, no action.
// - Gate stuck past timeout: latched pin and status, gates blocked, all but standby.
// - Thermal warning sets status, drivers active; pin only when reporting enabled.
// - Thermal warning status and pin release automatically when condition clears.
// - Thermal shutdown: pin low, status, gates blocked, standby+logic only.
// - Buck first limit: no report; cycle limiting unless buck overcurrent disabled.
// - Buck second limit: pin low, status, gates blocked, buck hiccup.
// - Buck overcurrent recovers only after soft-start done and current below limit.
// - Drive rail undervoltage: pin low, status, gates blocked, buck hiccup.
// - Drive rail undervoltage ends on recovery, plus soft-start done when enabled.
// - Drive rail overvoltage: pin low, status, gates blocked, pump and buck Hi-Z.
// - Drive rail overvoltage released when feedback falls below recovery level.
// - Pin latched only for overcurrent and gate faults; enable pulse or clear releases.
// - Motor undervoltage: gates blocked, standby+logic, pin low; auto resume.
// - Motor overvoltage: regulators restart automatically, gates wait for clear.
module gdfm_fault_manager import gdfm_pkg::*; #(
    parameter int RETRY_CYCLES = OC_RETRY_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Comparator flags and pins, asynchronous
    input wire logic enable_pin,
    input wire logic core_supply_undervolt,
    input wire logic motor_supply_undervolt,
    input wire logic motor_supply_overvolt,
    input wire logic pump_rail_undervolt,
    input wire logic [2:0] drain_source_overcurrent,
    input wire logic [2:0] shunt_sense_overcurrent,
    input wire logic gate_source_stuck,
    input wire logic thermal_warning,
    input wire logic thermal_shutdown,
    input wire logic buck_current_limit,
    input wire logic buck_overcurrent_fault,
    input wire logic drive_rail_undervolt,
    input wire logic drive_rail_overvolt,
    input wire logic buck_softstart_done,
    // Open-drain fault pin
    output logic fault_indicator_pin_o,
    output logic fault_indicator_pin_oe,
    // Power and driver controls
    output logic gate_block,
    output logic standby_regulator_en,
    output logic driver_linear_regulator_en,
    output logic logic_supply_regulator_en,
    output logic buck_en,
    output logic charge_pump_en,
    output logic buck_hiccup,
    output logic pump_buck_hiz,
    output logic buck_limit_en,
    output logic buck_limit_active
);

    function automatic logic oc_reports(input logic [1:0] m);
        oc_reports = (m != OC_OFF);
    endfunction : oc_reports

    function automatic logic oc_blocks(input logic [1:0] m, input logic pd);
        oc_blocks = (m == OC_LATCH_BLOCK) || ((m == OC_RETRY) && pd);
    endfunction : oc_blocks

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [IN_W-1:0] raw, s1_r, s2_r, s3_r, filt_r;
    assign raw = {buck_softstart_done, drive_rail_overvolt, drive_rail_undervolt, buck_overcurrent_fault,
                  buck_current_limit, thermal_shutdown, thermal_warning, gate_source_stuck,
                  shunt_sense_overcurrent, drain_source_overcurrent, pump_rail_undervolt,
                  motor_supply_overvolt, motor_supply_undervolt, core_supply_undervolt, enable_pin};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < IN_W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    filt_r[i] <= s2_r[i];
                end
            end
        end
    end

    logic en_c, core_uv, sup_uv, sup_ov, pump_uv, gate_stk, twarn, tsd, buck_lim, buck_oc, drv_uv, drv_ov, ss_done;
    logic [2:0] drain_oc, sense_oc;
    assign {ss_done, drv_ov, drv_uv, buck_oc, buck_lim, tsd, twarn, gate_stk,
            sense_oc, drain_oc, pump_uv, sup_ov, sup_uv, core_uv, en_c} = filt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register file and AXI4-Lite slave
    logic [DIS_W-1:0] dis_r;
    logic [MODE_W-1:0] mode_r;
    logic [ST_W-1:0] status_r, status_nxt;
    logic [LV_W-1:0] live;
    logic clear_cmd_r, en_prev_r, clear_evt;
    logic aw_hold_r, w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r == CTRL_OFS || awaddr_r == DISABLE_OFS || awaddr_r == MODE_OFS)
                               ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dis_r <= DIS_RST;
            mode_r <= MODE_RST;
            clear_cmd_r <= 1'b0;
        end else begin
            clear_cmd_r <= do_write && awaddr_r == CTRL_OFS && wstrb_r[0] && wdata_r[CLR_BIT];
            if (do_write && wstrb_r[0] && awaddr_r == DISABLE_OFS) begin
                dis_r <= wdata_r[DIS_W-1:0];
            end
            if (do_write && wstrb_r[0] && awaddr_r == MODE_OFS) begin
                mode_r <= wdata_r[MODE_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS: s_axi_rdata <= 32'h00000000;
                DISABLE_OFS: s_axi_rdata <= {{(32-DIS_W){1'b0}}, dis_r};
                MODE_OFS: s_axi_rdata <= {{(32-MODE_W){1'b0}}, mode_r};
                STATUS_OFS: s_axi_rdata <= {{(32-ST_W){1'b0}}, status_r};
                LIVE_OFS: s_axi_rdata <= {{(32-LV_W){1'b0}}, live};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode and clear events
    gdfm_mode_t op_mode_r;
    logic [1:0] drain_mode, sense_mode;
    logic pd_sel, twrep;
    assign drain_mode = mode_r[MODE_DRAIN_LSB +: 2];
    assign sense_mode = mode_r[MODE_SENSE_LSB +: 2];
    assign pd_sel = mode_r[MODE_PD_BIT];
    assign twrep = mode_r[MODE_TWREP_BIT];
    assign clear_evt = clear_cmd_r || (en_c && !en_prev_r);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_mode_r <= GDFM_SHUTDOWN;
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= en_c;
            case (op_mode_r)
                GDFM_SHUTDOWN: op_mode_r <= core_uv ? GDFM_SHUTDOWN : GDFM_SLEEP;
                GDFM_SLEEP: op_mode_r <= core_uv ? GDFM_SHUTDOWN : (en_c ? GDFM_OPERATING : GDFM_SLEEP);
                GDFM_OPERATING: op_mode_r <= core_uv ? GDFM_SHUTDOWN : (en_c ? GDFM_OPERATING : GDFM_SLEEP);
                default: op_mode_r <= GDFM_SHUTDOWN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enabled fault terms
    logic up, sup_uv_f, sup_ov_f, pump_f, tsd_f, drv_ov_f, drain_any, sense_any;
    assign up = (op_mode_r == GDFM_OPERATING);
    assign sup_uv_f = up && sup_uv && !dis_r[DIS_SUP_UV];
    assign sup_ov_f = up && sup_ov && !dis_r[DIS_SUP_OV];
    assign pump_f = up && pump_uv && !dis_r[DIS_PUMP_UV];
    assign tsd_f = up && tsd && !dis_r[DIS_TSD];
    assign drv_ov_f = up && drv_ov && !dis_r[DIS_DRV_OV];
    assign drain_any = |drain_oc;
    assign sense_any = |sense_oc;

    // Latched and held faults
    logic drain_lat_r, sense_lat_r, gate_lat_r, ov_hold_r, buck_oc_r, drv_uv_r;
    logic [RETRY_CNT_W-1:0] drain_cnt_r, sense_cnt_r;
    logic drain_exp, sense_exp;
    assign drain_exp = drain_lat_r && drain_mode == OC_RETRY && drain_cnt_r == RETRY_CNT_W'(RETRY_CYCLES - 1);
    assign sense_exp = sense_lat_r && sense_mode == OC_RETRY && sense_cnt_r == RETRY_CNT_W'(RETRY_CYCLES - 1);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            drain_lat_r <= 1'b0;
            drain_cnt_r <= '0;
        end else begin
            if (up && drain_any && oc_reports(drain_mode)) begin
                drain_lat_r <= 1'b1;
            end else if ((clear_evt || drain_exp) && !drain_any) begin
                drain_lat_r <= 1'b0;
            end
            if (drain_lat_r && drain_mode == OC_RETRY && !drain_exp) begin
                drain_cnt_r <= drain_cnt_r + RETRY_CNT_W'(1);
            end else begin
                drain_cnt_r <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sense_lat_r <= 1'b0;
            sense_cnt_r <= '0;
        end else begin
            if (up && sense_any && oc_reports(sense_mode)) begin
                sense_lat_r <= 1'b1;
            end else if ((clear_evt || sense_exp) && !sense_any) begin
                sense_lat_r <= 1'b0;
            end
            if (sense_lat_r && sense_mode == OC_RETRY && !sense_exp) begin
                sense_cnt_r <= sense_cnt_r + RETRY_CNT_W'(1);
            end else begin
                sense_cnt_r <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_lat_r <= 1'b0;
            ov_hold_r <= 1'b0;
            buck_oc_r <= 1'b0;
            drv_uv_r <= 1'b0;
        end else begin
            if (up && gate_stk && !dis_r[DIS_GATE]) begin
                gate_lat_r <= 1'b1;
            end else if (clear_evt && !gate_stk) begin
                gate_lat_r <= 1'b0;
            end
            if (sup_ov_f) begin
                ov_hold_r <= 1'b1;
            end else if (clear_evt) begin
                ov_hold_r <= 1'b0;
            end
            if (up && buck_oc && !dis_r[DIS_BUCK_OC]) begin
                buck_oc_r <= 1'b1;
            end else if (ss_done && !buck_oc) begin
                buck_oc_r <= 1'b0;
            end
            if (up && drv_uv && !dis_r[DIS_DRV_UV]) begin
                drv_uv_r <= 1'b1;
            end else if (!drv_uv && (ss_done || dis_r[DIS_DRV_UV])) begin
                drv_uv_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status bits, set wins over clear
    always_comb begin
        status_nxt = clear_evt ? '0 : status_r;
        if (up) begin
            status_nxt[ST_SUP_UV] = status_nxt[ST_SUP_UV] | sup_uv;
            status_nxt[ST_SUP_OV] = status_nxt[ST_SUP_OV] | sup_ov;
            status_nxt[ST_PUMP_UV] = status_nxt[ST_PUMP_UV] | pump_uv;
            status_nxt[ST_DRAIN] = status_nxt[ST_DRAIN] | (drain_any && oc_reports(drain_mode));
            status_nxt[ST_SENSE] = status_nxt[ST_SENSE] | (sense_any && oc_reports(sense_mode));
            status_nxt[ST_GATE] = status_nxt[ST_GATE] | (gate_stk && !dis_r[DIS_GATE]);
            status_nxt[ST_TSD] = status_nxt[ST_TSD] | tsd;
            status_nxt[ST_BUCK_OC] = status_nxt[ST_BUCK_OC] | buck_oc;
            status_nxt[ST_DRV_UV] = status_nxt[ST_DRV_UV] | drv_uv;
            status_nxt[ST_DRV_OV] = status_nxt[ST_DRV_OV] | drv_ov;
        end
        status_nxt[ST_TWARN] = up && twarn;
        status_nxt[ST_ANY] = |status_nxt[ST_W-1:ST_SUP_UV];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= '0;
        end else begin
            status_r <= core_uv ? '0 : status_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protective actions and outputs
    logic pin_low, block_c, only_stby, buck_off;
    assign pin_low = up && (sup_uv_f || sup_ov_f || pump_f || drain_lat_r || sense_lat_r || gate_lat_r
                     || (twarn && twrep) || tsd_f || buck_oc_r || drv_uv_r || drv_ov_f);
    assign block_c = !up || sup_uv_f || ov_hold_r || pump_f || gate_lat_r || tsd_f || buck_oc_r
                     || drv_uv_r || drv_ov_f
                     || (drain_lat_r && oc_blocks(drain_mode, pd_sel))
                     || (sense_lat_r && oc_blocks(sense_mode, pd_sel));
    assign only_stby = !up || sup_uv_f || sup_ov_f || tsd_f || buck_oc_r || drv_uv_r;
    assign buck_off = only_stby || drv_ov_f;
    assign live = {pump_buck_hiz, buck_hiccup, buck_en, driver_linear_regulator_en, standby_regulator_en,
                   !fault_indicator_pin_oe, gate_block, op_mode_r};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_indicator_pin_oe <= 1'b0;
            gate_block <= 1'b1;
            standby_regulator_en <= 1'b1;
            driver_linear_regulator_en <= 1'b0;
            logic_supply_regulator_en <= 1'b1;
            buck_en <= 1'b0;
            charge_pump_en <= 1'b0;
            buck_hiccup <= 1'b0;
            pump_buck_hiz <= 1'b0;
            buck_limit_en <= 1'b1;
            buck_limit_active <= 1'b0;
        end else begin
            fault_indicator_pin_oe <= pin_low;
            gate_block <= block_c;
            standby_regulator_en <= only_stby || drv_ov_f;
            driver_linear_regulator_en <= !only_stby;
            logic_supply_regulator_en <= 1'b1;
            buck_en <= !buck_off;
            charge_pump_en <= !buck_off;
            buck_hiccup <= up && (buck_oc_r || drv_uv_r);
            pump_buck_hiz <= drv_ov_f;
            buck_limit_en <= !dis_r[DIS_BUCK_OC];
            buck_limit_active <= up && buck_lim && !dis_r[DIS_BUCK_OC];
        end
    end

    assign fault_indicator_pin_o = 1'b0;

endmodule : gdfm_fault_manager

//--- test/gdfm_monitor.sv
`timescale 1ns/1ps
module gdfm_monitor (
    // Clock, reset and cause
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic core_supply_undervolt,
    // Pin and power outputs
    input wire logic fault_indicator_pin_o,
    input wire logic fault_indicator_pin_oe,
    input wire logic gate_block,
    input wire logic standby_regulator_en,
    input wire logic driver_linear_regulator_en,
    input wire logic logic_supply_regulator_en,
    input wire logic buck_en,
    input wire logic charge_pump_en,
    input wire logic buck_hiccup,
    input wire logic pump_buck_hiz,
    input wire logic buck_limit_en,
    input wire logic buck_limit_active
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_core_low;
        core_supply_undervolt [*8];
    endsequence
    a_core_uv_off: assert property (s_core_low |-> gate_block && !fault_indicator_pin_oe && standby_regulator_en)
        else $error("core undervolt response wrong");
    a_pin_od_only: assert property (!fault_indicator_pin_o)
        else $error("fault pin driven high");
    a_logic_ldo_on: assert property (logic_supply_regulator_en)
        else $error("logic regulator off");
    a_limit_needs_en: assert property (buck_limit_active |-> buck_limit_en)
        else $error("limiting while disabled");
    a_hiz_blocks: assert property (pump_buck_hiz |-> gate_block && driver_linear_regulator_en)
        else $error("hiz without block");
    a_hiccup_blocks: assert property (buck_hiccup |-> gate_block && standby_regulator_en)
        else $error("hiccup without block");
    a_standby_excl: assert property (driver_linear_regulator_en && !pump_buck_hiz |-> !standby_regulator_en)
        else $error("standby on with driver regulator");
    a_free_powered: assert property (!gate_block |-> buck_en && charge_pump_en && driver_linear_regulator_en)
        else $error("drivers active without power chain");
endmodule : gdfm_monitor

bind gdfm_fault_manager gdfm_monitor gdfm_monitor_inst (
    .ref_clk, .reset_n, .core_supply_undervolt, .fault_indicator_pin_o, .fault_indicator_pin_oe,
    .gate_block, .standby_regulator_en, .driver_linear_regulator_en, .logic_supply_regulator_en,
    .buck_en, .charge_pump_en, .buck_hiccup, .pump_buck_hiz, .buck_limit_en, .buck_limit_active);

//--- test/gdfm_host_model.sv
`timescale 1ns/1ps
module gdfm_host_model (
    // Clock and command
    input wire logic ref_clk,
    input wire logic wake,
    // Fault pin
    input wire logic fault_indicator_pin_o,
    input wire logic fault_indicator_pin_oe,
    output logic fault_line,
    // Enable pin
    output logic enable_pin
);
    // Pull-up holds the line high once released
    assign fault_line = fault_indicator_pin_oe ? fault_indicator_pin_o : 1'b1;
    always @(posedge ref_clk) begin
        enable_pin <= wake;
    end
endmodule : gdfm_host_model

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import gdfm_pkg::*;
    typedef struct {logic [7:0] m; logic [7:0] d; logic [17:0] p; logic [3:0] lv; logic [11:0] st; logic lat;} gdfm_case_t;
    localparam logic [17:0] IDLE = 18'h10000;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wake = 1'b0;
    logic [17:0] f = IDLE;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, enable_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic fault_indicator_pin_o, fault_indicator_pin_oe, gate_block, standby_regulator_en, buck_en;
    logic driver_linear_regulator_en, logic_supply_regulator_en, charge_pump_en, buck_hiccup;
    logic pump_buck_hiz, buck_limit_en, buck_limit_active, fault_line;
    logic [65:0] rq[$];
    logic [65:0] q;
    logic [1:0] wq[$];
    logic [17:0] p;
    int errors = 0;
    int n_checks = 0;
    gdfm_case_t tc[15] = '{
        '{8'h00, 8'h00, 18'h1, 4'h4, 12'h008, 1'b0},
        '{8'h00, 8'h00, 18'h2, 4'h4, 12'h010, 1'b1},
        '{8'h02, 8'h00, 18'h2, 4'h0, 12'h010, 1'b1},
        '{8'h00, 8'h00, 18'h10, 4'h4, 12'h020, 1'b1},
        '{8'h08, 8'h00, 18'h10, 4'h0, 12'h020, 1'b1},
        '{8'h03, 8'h00, 18'h2, 4'h8, 12'h000, 1'b0},
        '{8'h00, 8'h08, 18'h80, 4'h8, 12'h000, 1'b0},
        '{8'h00, 8'h00, 18'h80, 4'h4, 12'h040, 1'b1},
        '{8'h00, 8'h04, 18'h1, 4'h8, 12'h008, 1'b0},
        '{8'h00, 8'h00, 18'h100, 4'h8, 12'h080, 1'b0},
        '{8'h20, 8'h00, 18'h100, 4'h0, 12'h080, 1'b0},
        '{8'h11, 8'h00, 18'h2, 4'h4, 12'h010, 1'b0},
        '{8'h00, 8'h00, 18'h200, 4'h4, 12'h200, 1'b0},
        '{8'h00, 8'h00, 18'h400, 4'h4, 12'h800, 1'b0},
        '{8'h00, 8'h00, 18'h800, 4'h8, 12'h000, 1'b0}};
    gdfm_fault_manager #(.RETRY_CYCLES(8)) gdfm_fault_manager_inst (.*, .core_supply_undervolt(f[17]),
        .motor_supply_undervolt(f[12]), .motor_supply_overvolt(f[13]), .pump_rail_undervolt(f[0]),
        .drain_source_overcurrent(f[3:1]), .shunt_sense_overcurrent(f[6:4]), .gate_source_stuck(f[7]),
        .thermal_warning(f[8]), .thermal_shutdown(f[14]), .buck_current_limit(f[11]),
        .buck_overcurrent_fault(f[9]), .drive_rail_undervolt(f[15]), .drive_rail_overvolt(f[10]),
        .buck_softstart_done(f[16]));
    gdfm_host_model gdfm_host_model_inst (.ref_clk, .wake, .fault_indicator_pin_o, .fault_indicator_pin_oe,
        .fault_line(fault_line), .enable_pin);
    initial forever #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    always @(posedge ref_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            q = rq.pop_front();
            cmp(s_axi_rdata & q[65:34], q[33:2]);
            cmp(32'(s_axi_rresp), 32'(q[1:0]));
        end
        if (s_axi_bvalid && s_axi_bready) cmp(32'(s_axi_bresp), 32'(wq.pop_front()));
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        rq.push_back({m, e, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(51));
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd(LIVE_OFS, 32'h1FF, 32'h01D, RESP_OKAY);
        rd(8'h14, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        wr(STATUS_OFS, 32'h0, RESP_SLVERR);
        wake <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rd(LIVE_OFS, 32'h1FF, 32'h06A, RESP_OKAY);
        foreach (tc[i]) begin
            p = tc[i].p;
            if (|(p & 18'h12)) p = p << ($urandom % 3);
            wr(MODE_OFS, {24'h0, tc[i].m}, RESP_OKAY);
            wr(DISABLE_OFS, {24'h0, tc[i].d}, RESP_OKAY);
            f <= p | IDLE;
            repeat (8) @(posedge ref_clk);
            rd(LIVE_OFS, 32'hC, {28'h0, tc[i].lv}, RESP_OKAY);
            cmp(32'(fault_line), 32'(tc[i].lv[3]));
            rd(STATUS_OFS, 32'hFFE, {20'h0, tc[i].st}, RESP_OKAY);
            f <= IDLE;
            repeat (30) @(posedge ref_clk);
            rd(LIVE_OFS, 32'h8, {28'h0, ~tc[i].lat, 3'h0}, RESP_OKAY);
            if (i == 7) begin
                wake <= 1'b0;
                repeat (8) @(posedge ref_clk);
                wake <= 1'b1;
                repeat (12) @(posedge ref_clk);
            end else begin
                wr(CTRL_OFS, 32'h1, RESP_OKAY);
                repeat (6) @(posedge ref_clk);
            end
            rd(LIVE_OFS, 32'hC, 32'h8, RESP_OKAY);
            rd(STATUS_OFS, 32'hFFE, 32'h0, RESP_OKAY);
            $display("test %0d done", i);
        end
        f <= IDLE | 18'h20000;
        repeat (12) @(posedge ref_clk);
        rd(LIVE_OFS, 32'h1FF, 32'h01C, RESP_OKAY);
        tally_and_finish();
    end
endmodule : testbench
